// >>> include/stats_pkg.sv
/*
  Shared constants and carrier types for the port statistics counter bank:
  register offsets, indirect space layout, length limits, counter slots and
  the frame event structs that the port MACs deliver.
  Assumes nothing beyond a SystemVerilog compiler; no timescale here.
*/
package stats_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_PORTS = 3;
  localparam int NUM_SLOTS = 32;
  localparam int CNT_W = 30;
  localparam int LEN_W = 11;
  localparam int DROP_W = 16;
  localparam int NUM_DROP = 6;

  // ==========================================================================
  // Wishbone register byte offsets and fields
  localparam logic [7:0] ADR_TABLE_SEL = 8'h00;
  localparam logic [7:0] ADR_TRIGGER = 8'h04;
  localparam logic [7:0] ADR_DATA = 8'h08;
  localparam logic [7:0] ADR_CONFIG = 8'h0c;
  localparam logic [7:0] SEL_PORT_CNT = 8'h1c;
  localparam logic [7:0] SEL_DROP_CNT = 8'h1d;
  localparam int BIT_OVF = 31;
  localparam int BIT_VALID = 30;
  localparam int BIT_CFG_LONG = 0;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic CFG_LONG_RST = 1'b0;

  // ==========================================================================
  // Indirect space
  localparam logic [8:0] PORT_SPAN = 9'h060;
  localparam logic [8:0] PORT_STRIDE = 9'h020;
  localparam logic [8:0] DROP_TX_BASE = 9'h100;
  localparam logic [8:0] DROP_RX_BASE = 9'h103;

  // ==========================================================================
  // Length limits in bytes
  localparam logic [10:0] LEN_MIN = 11'h040;
  localparam logic [10:0] LEN_B127 = 11'h07f;
  localparam logic [10:0] LEN_B255 = 11'h0ff;
  localparam logic [10:0] LEN_B511 = 11'h1ff;
  localparam logic [10:0] LEN_B1023 = 11'h3ff;
  localparam logic [10:0] LEN_MAX_STD = 11'h5f2;
  localparam logic [10:0] LEN_MAX_EXT = 11'h600;

  // ==========================================================================
  // Counter slots within one port
  localparam int C_RX_LO_OCT = 0, C_RX_HI_OCT = 1, C_RX_SHORT_OK = 2;
  localparam int C_RX_SHORT_BAD = 3, C_RX_LONG_OK = 4, C_RX_LONG_BAD = 5;
  localparam int C_RX_SYM = 6, C_RX_CRC = 7, C_RX_ALIGN = 8;
  localparam int C_RX_CTRL = 9, C_RX_PAUSE = 10, C_RX_BCAST = 11;
  localparam int C_RX_MCAST = 12, C_RX_UCAST = 13, C_RX_BIN_MIN = 14;
  localparam int C_TX_LO_OCT = 20, C_TX_HI_OCT = 21, C_TX_LATE = 22;
  localparam int C_TX_PAUSE = 23, C_TX_BCAST = 24, C_TX_MCAST = 25;
  localparam int C_TX_UCAST = 26, C_TX_DEFER = 27, C_TX_COL_TOTAL = 28;
  localparam int C_TX_COL_ABORT = 29, C_TX_COL_ONE = 30, C_TX_COL_MANY = 31;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic valid;          // One-cycle pulse at end of frame
    logic [10:0] len;     // Frame length in bytes
    logic high_prio;
    logic crc_ok;
    logic partial_byte;   // Non-integral number of bytes
    logic symbol_err;
    logic bcast;
    logic mcast;
    logic mac_ctrl;       // EtherType 88-08h
    logic pause_op;       // Control opcode 00-01
    logic da_ok;          // Destination qualifies for PAUSE
  } rx_event_t;

  typedef struct packed {
    logic valid;          // One-cycle pulse at end of attempt
    logic [10:0] len;
    logic high_prio;
    logic ok;             // Sent successfully
    logic pause;
    logic bcast;
    logic mcast;
    logic late_collide;
    logic deferred;
    logic abort;          // Excessive collisions
    logic [4:0] collisions;
  } tx_event_t;

  typedef logic [31:0][10:0] inc_vec_t;

endpackage : stats_pkg

// >>> core/port_statistics_counters.sv
/*
  Statistics counter bank for a three-port switch: per-port receive and
  transmit counters, clear on read, plus shared dropped-packet counters,
  read through a table-select / trigger / data window on classic Wishbone.
  Assumes frame events arrive as one-cycle pulses synchronous to i_ref_clk
  and that the management host follows the select-then-trigger sequence.
*/
// How it works
// - Thirty-two counters kept for every switch port
// - Thirty-bit count with sticky overflow flag
// - Bit thirty set only for valid count
// - Ports based at 0x00, 0x20, 0x40
// - Slots 0,1 add received octets per priority
// - Short good-CRC and short bad frames counted
// - Long good-CRC frames over 1522/1536 counted
// - Long errored frames counted at slot 5
// - Legal-size frames with bad symbol counted
// - Bad CRC split by whole/partial bytes
// - MAC control frames 88-08h counted
// - Fully qualified PAUSE frames counted
// - Good broadcast, multicast, unicast received counted
// - Received frames binned by length
// - Good transmitted octets per priority added
// - Late collisions past 512 bit-times counted
// - Transmitted PAUSE and good cast types counted
// - Deferred first transmission attempts counted
// - Collision totals, aborts, single, multiple counted
// - Drop counters sixteen bits, upper reserved
// - Drop counters at 0x100 to 0x105
// - Port counters clear on read; drops persist

`timescale 1ns/1ps

module port_statistics_counters (
  input wire logic i_ref_clk,                          // 50 MHz core clock
  input wire logic i_reset,                            // Async, active high
  input wire logic i_wb_cyc,                           // Wishbone cycle
  input wire logic i_wb_stb,                           // Wishbone strobe
  input wire logic i_wb_we,                            // Write enable
  input wire logic [7:0] i_wb_adr,                     // Byte address
  input wire logic [31:0] i_wb_dat,                    // Write data
  input wire logic [3:0] i_wb_sel,                     // Byte enables
  output logic [31:0] o_wb_dat,                        // Read data
  output logic o_wb_ack,                               // Acknowledge
  input stats_pkg::rx_event_t [2:0] i_rx_event,        // Rx end of frame
  input stats_pkg::tx_event_t [2:0] i_tx_event,        // Tx end of frame
  input wire logic [2:0] i_tx_drop,                    // Tx drop pulses
  input wire logic [2:0] i_rx_drop                     // Rx drop pulses
);
  import stats_pkg::*;

  // ==========================================================================
  // Increment builders
  function automatic inc_vec_t rx_inc(input rx_event_t e,
                                      input logic long_mode);
    inc_vec_t v;
    logic [10:0] lim;
    logic short_f;
    logic long_f;
    logic bad;
    logic good;
    v = '0;
    lim = long_mode ? LEN_MAX_EXT : LEN_MAX_STD;
    short_f = e.len < LEN_MIN;
    long_f = e.len > lim;
    bad = !e.crc_ok || e.symbol_err || e.partial_byte;
    good = !bad && !short_f && !long_f;
    if (e.valid) begin
      if (e.high_prio) begin
        v[C_RX_HI_OCT] = e.len;
      end else begin
        v[C_RX_LO_OCT] = e.len;
      end
      v[C_RX_SHORT_OK] = {10'h000, short_f && !bad};
      v[C_RX_SHORT_BAD] = {10'h000, short_f && bad};
      v[C_RX_LONG_OK] = {10'h000, long_f && e.crc_ok};
      v[C_RX_LONG_BAD] = {10'h000, long_f && bad};
      v[C_RX_SYM] = {10'h000, e.symbol_err && !short_f
                     && !long_f};
      v[C_RX_CRC] = {10'h000, !short_f && !long_f && !e.crc_ok
                     && !e.partial_byte};
      v[C_RX_ALIGN] = {10'h000, !short_f && !long_f && !e.crc_ok
                       && e.partial_byte};
      v[C_RX_CTRL] = {10'h000, e.mac_ctrl};
      v[C_RX_PAUSE] = {10'h000, e.mac_ctrl && e.da_ok && e.pause_op
                       && !short_f && e.crc_ok};
      v[C_RX_BCAST] = {10'h000, good && e.bcast};
      v[C_RX_MCAST] = {10'h000, good && e.mcast && !e.bcast
                       && !e.mac_ctrl};
      v[C_RX_UCAST] = {10'h000, good && !e.mcast && !e.bcast};
      v[C_RX_BIN_MIN] = {10'h000, e.len == LEN_MIN};
      v[C_RX_BIN_MIN + 1] = {10'h000, e.len > LEN_MIN
                             && e.len <= LEN_B127};
      v[C_RX_BIN_MIN + 2] = {10'h000, e.len > LEN_B127
                             && e.len <= LEN_B255};
      v[C_RX_BIN_MIN + 3] = {10'h000, e.len > LEN_B255
                             && e.len <= LEN_B511};
      v[C_RX_BIN_MIN + 4] = {10'h000, e.len > LEN_B511
                             && e.len <= LEN_B1023};
      v[C_RX_BIN_MIN + 5] = {10'h000, e.len > LEN_B1023
                             && !long_f};
    end
    return v;
  endfunction : rx_inc

  function automatic inc_vec_t tx_inc(input tx_event_t e);
    inc_vec_t v;
    logic uni;
    v = '0;
    uni = !e.bcast && !e.mcast;
    if (e.valid) begin
      if (e.ok && e.high_prio) begin
        v[C_TX_HI_OCT] = e.len;
      end else if (e.ok) begin
        v[C_TX_LO_OCT] = e.len;
      end
      v[C_TX_LATE] = {10'h000, e.late_collide};
      v[C_TX_PAUSE] = {10'h000, e.ok && e.pause};
      v[C_TX_BCAST] = {10'h000, e.ok && !e.pause && e.bcast};
      v[C_TX_MCAST] = {10'h000, e.ok && !e.pause && e.mcast
                       && !e.bcast};
      v[C_TX_UCAST] = {10'h000, e.ok && !e.pause && uni};
      v[C_TX_DEFER] = {10'h000, e.deferred};
      v[C_TX_COL_TOTAL] = {6'h00, e.collisions};
      v[C_TX_COL_ABORT] = {10'h000, e.abort};
      v[C_TX_COL_ONE] = {10'h000, e.ok && e.collisions == 5'h01};
      v[C_TX_COL_MANY] = {10'h000, e.ok && e.collisions > 5'h01};
    end
    return v;
  endfunction : tx_inc

  // ==========================================================================
  // Storage
  // Flops rather than RAM: every slot may take an event in the same cycle.
  logic [CNT_W-1:0] cnt [NUM_PORTS][NUM_SLOTS];
  logic ovf [NUM_PORTS][NUM_SLOTS];
  logic [CNT_W-1:0] next_cnt [NUM_PORTS][NUM_SLOTS];
  logic next_ovf [NUM_PORTS][NUM_SLOTS];
  logic [DROP_W-1:0] drop [NUM_DROP];
  logic [7:0] table_sel;
  logic cfg_long;

  // ==========================================================================
  // Bus decode
  wire bus_req = i_wb_cyc && i_wb_stb;
  wire bus_take = bus_req && o_wb_ack;
  wire wr_lane0 = bus_take && i_wb_we && i_wb_sel[0];
  wire hit_sel = i_wb_adr == ADR_TABLE_SEL;
  wire hit_trig = i_wb_adr == ADR_TRIGGER;
  wire hit_data = i_wb_adr == ADR_DATA;
  wire hit_cfg = i_wb_adr == ADR_CONFIG;
  wire wr_sel = wr_lane0 && hit_sel;
  wire wr_cfg = wr_lane0 && hit_cfg;
  wire trigger = wr_lane0 && hit_trig;
  wire sel_port = table_sel == SEL_PORT_CNT;
  wire sel_drop = table_sel == SEL_DROP_CNT;

  // Indirect address: the select's low bit is address bit 8
  wire [8:0] ind_adr = {table_sel[0], i_wb_dat[7:0]};
  wire port_hit = sel_port && ind_adr < PORT_SPAN;
  wire [1:0] rd_port = ind_adr[6:5];
  wire [4:0] rd_slot = ind_adr[4:0];
  wire drop_hit = sel_drop && ind_adr >= DROP_TX_BASE
                  && ind_adr < DROP_RX_BASE + 9'h003;
  wire [8:0] drop_off = ind_adr - DROP_TX_BASE;
  wire [2:0] drop_idx = drop_off[2:0];

  // Snapshot returned on a trigger
  wire [31:0] port_word = {ovf[rd_port][rd_slot], 1'b1,
                           cnt[rd_port][rd_slot]};
  wire [31:0] drop_word = {16'h0000, drop[drop_idx]};
  wire [31:0] next_snap = port_hit ? port_word :
                          drop_hit ? drop_word : DATA_RST;
  logic [31:0] snap;

  wire [31:0] rd_mux = hit_sel ? {24'h000000, table_sel} :
                       hit_data ? snap :
                       hit_cfg ? {31'h00000000, cfg_long} :
                       32'h0000_0000;

  // ==========================================================================
  // Counter next values
  genvar gp;
  genvar gs;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      wire inc_vec_t inc = rx_inc(i_rx_event[gp], cfg_long)
                           | tx_inc(i_tx_event[gp]);
      for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_slot
        wire clr = trigger && port_hit && rd_port == 2'(gp)
                   && rd_slot == 5'(gs);
        wire [CNT_W:0] sum = {1'b0, cnt[gp][gs]}
                             + {20'h00000, inc[gs]};
        // A read and an event together: the event survives the clear
        assign next_cnt[gp][gs] = clr ? {19'h00000, inc[gs]}
                                      : sum[CNT_W-1:0];
        assign next_ovf[gp][gs] = clr ? 1'b0
                                      : ovf[gp][gs] | sum[CNT_W];
      end
    end
  endgenerate

  wire [NUM_DROP-1:0] drop_ev = {i_rx_drop, i_tx_drop};

  // ==========================================================================
  // Counter registers
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int s = 0; s < NUM_SLOTS; s++) begin
          cnt[p][s] <= '0;
          ovf[p][s] <= 1'b0;
        end
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int s = 0; s < NUM_SLOTS; s++) begin
          cnt[p][s] <= next_cnt[p][s];
          ovf[p][s] <= next_ovf[p][s];
        end
      end
    end
  end

  // Drop counters wrap silently and are not cleared by reading
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int d = 0; d < NUM_DROP; d++) begin
        drop[d] <= '0;
      end
    end else begin
      for (int d = 0; d < NUM_DROP; d++) begin
        drop[d] <= drop[d] + {15'h0000, drop_ev[d]};
      end
    end
  end

  // ==========================================================================
  // Window registers
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      table_sel <= SEL_RST;
      cfg_long <= CFG_LONG_RST;
      snap <= DATA_RST;
    end else begin
      if (wr_sel) begin
        table_sel <= i_wb_dat[7:0];
      end
      if (wr_cfg) begin
        cfg_long <= i_wb_dat[BIT_CFG_LONG];
      end
      if (trigger) begin
        snap <= next_snap;
      end
    end
  end

  // ==========================================================================
  // Wishbone answer: one wait state, ack for a single cycle
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= DATA_RST;
    end else begin
      o_wb_ack <= bus_req && !o_wb_ack;
      o_wb_dat <= (bus_req && !o_wb_ack && !i_wb_we) ? rd_mux
                                                      : DATA_RST;
    end
  end

endmodule : port_statistics_counters

// >>> test/port_statistics_counters_props.sv
/*
  Bus-side checker for the statistics bank.
  Bound to the bank; sees only its Wishbone ports.
*/
`timescale 1ns/1ps
module stats_props (
  input wire logic i_ref_clk, // Core clock
  input wire logic i_reset, // Async reset
  input wire logic i_wb_cyc, // Cycle
  input wire logic i_wb_stb, // Strobe
  input wire logic i_wb_we, // Write
  input wire logic [7:0] i_wb_adr, // Address
  input wire logic [31:0] i_wb_dat, // Write data
  input wire logic [3:0] i_wb_sel, // Byte enables
  input wire logic [31:0] o_wb_dat, // Read data
  input wire logic o_wb_ack // Ack
);
  import stats_pkg::*;
  // ==========================================================================
  // Shadow of the table and offset behind the last snapshot
  logic [7:0] tsel, snap, toff;
  logic have;
  wire req = i_wb_cyc & i_wb_stb;
  wire wr = o_wb_ack & req & i_wb_we & i_wb_sel[0];
  wire rd = o_wb_ack & req & !i_wb_we & (i_wb_adr == ADR_DATA);
  wire pt = (snap == SEL_PORT_CNT) && (toff < 8'h60);
  wire dr = (snap == SEL_DROP_CNT) && (toff < 8'h06);
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      tsel <= SEL_RST;
      snap <= SEL_RST;
      toff <= 8'h00;
      have <= 1'b0;
    end else if (wr && i_wb_adr == ADR_TABLE_SEL) begin
      tsel <= i_wb_dat[7:0];
    end else if (wr && i_wb_adr == ADR_TRIGGER) begin
      snap <= tsel;
      toff <= i_wb_dat[7:0];
      have <= 1'b1;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  chk_ack_follows: assert property (req && !o_wb_ack |-> ##1 o_wb_ack)
    else $error("ack missing one cycle after request");
  chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  chk_ack_cause: assert property ($rose(o_wb_ack) |-> $past(req))
    else $error("ack without request");
  chk_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data not zero outside ack");
  chk_valid_bit: assert property (rd && have && pt
    |-> o_wb_dat[BIT_VALID])
    else $error("valid bit low on counter snapshot");
  chk_valid_clear: assert property (rd && !have |-> o_wb_dat == DATA_RST)
    else $error("data window not cleared by reset");
  chk_drop_upper: assert property (rd && have && dr
    |-> o_wb_dat[31:16] == 16'h0)
    else $error("drop counter upper bits not zero");
  chk_unmapped_zero: assert property (rd && have && !pt && !dr
    |-> o_wb_dat == 32'h0)
    else $error("unmapped entry reads nonzero");
endmodule : stats_props

bind port_statistics_counters stats_props i_stats_props (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack)
);

// >>> test/stats_host_model.sv
/*
  Management host model: classic Wishbone single cycles and the
  select, trigger and read sequence of the counter window.
  Assumes the bank answers every request with an ack.
*/
`timescale 1ns/1ps
module stats_host_model (
  input wire logic i_clk, // Core clock
  input wire logic i_ack, // Bus ack
  input wire logic [31:0] i_dat, // Read data
  output logic o_cyc, // Cycle
  output logic o_stb, // Strobe
  output logic o_we, // Write
  output logic [7:0] o_adr, // Address
  output logic [31:0] o_dat, // Write data
  output logic [3:0] o_sel // Byte enables
);
  import stats_pkg::*;
  initial begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we = 1'b0;
    o_adr = 8'h00;
    o_dat = 32'h0;
    o_sel = 4'hf;
  end
  // ==========================================================================
  // Bus cycle; released address and write data show the inverse so stale values never pass
  task access(input logic w, input logic [7:0] a, input logic [31:0] wd,
              output logic [31:0] rd);
    @(posedge i_clk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we <= w;
    o_adr <= a;
    o_dat <= wd;
    // No cycle limit here: only the bench watchdog ends a stalled wait
    do begin
      @(posedge i_clk);
    end while (i_ack !== 1'b1);
    rd = i_dat;
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    o_adr <= ~a;
    o_dat <= ~wd;
  endtask : access
  task rd_counter(input logic [8:0] idx, output logic [31:0] d);
    logic [31:0] u;
    int n;
    access(1'b1, ADR_TABLE_SEL, {24'h0, idx[8] ? SEL_DROP_CNT : SEL_PORT_CNT},
           u);
    access(1'b1, ADR_TRIGGER, {24'h0, idx[7:0]}, u);
    access(1'b0, ADR_DATA, 32'h0, d);
    n = 0;
    while (idx < PORT_SPAN && !d[BIT_VALID] && n < 2) begin
      access(1'b0, ADR_DATA, 32'h0, d);
      n++;
    end
  endtask : rd_counter
endmodule : stats_host_model

// >>> test/port_statistics_counters_tb.sv
/*
  Bench for the statistics bank: random frame events against an integer
  model, every counter read back through the host model.
  Assumes stats_pkg, the bank, the host model and the checker.
*/
`timescale 1ns/1ps
module port_statistics_counters_tb;
  import stats_pkg::*;
  logic clk, rst, cyc, stb, we, ack;
  rx_event_t [2:0] rx_ev;
  tx_event_t [2:0] tx_ev;
  logic [2:0] txd, rxd;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, d, x;
  logic [31:0] seed = 32'h32;
  int cnt[96];
  int drp[6];
  bit cfg;
  int miscompares, num_checks;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  port_statistics_counters i_port_statistics_counters (
    .i_ref_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_rx_event(rx_ev),
    .i_tx_event(tx_ev), .i_tx_drop(txd), .i_rx_drop(rxd));
  stats_host_model i_stats_host_model (
    .i_clk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb),
    .o_we(we), .o_adr(adr), .o_dat(wdat), .o_sel(sel));
  // ==========================================================================
  // Helpers and model
  function logic [31:0] rnd();
    for (int i = 0; i < 32; i++) seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed;
  endfunction : rnd
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task mdl_rx(input int p, input rx_event_t e);
    int b, l, lim;
    bit bad, good;
    b = p * 32;
    l = e.len;
    lim = cfg ? LEN_MAX_EXT : LEN_MAX_STD;
    bad = !e.crc_ok | e.symbol_err | e.partial_byte;
    good = !bad && l >= LEN_MIN && l <= lim;
    cnt[b + e.high_prio] += l;
    if (l < LEN_MIN) cnt[b + (bad ? 3 : 2)]++;
    if (l > lim && e.crc_ok) cnt[b + 4]++;
    if (l > lim && bad) cnt[b + 5]++;
    if (l >= LEN_MIN && l <= lim) begin
      if (e.symbol_err) cnt[b + 6]++;
      if (!e.crc_ok) cnt[b + (e.partial_byte ? 8 : 7)]++;
      cnt[b + (l == LEN_MIN ? 14 : l <= LEN_B127 ? 15 : l <= LEN_B255 ? 16 :
          l <= LEN_B511 ? 17 : l <= LEN_B1023 ? 18 : 19)]++;
    end
    if (e.mac_ctrl) cnt[b + 9]++;
    if (e.mac_ctrl && e.da_ok && e.pause_op && l >= LEN_MIN && e.crc_ok)
      cnt[b + 10]++;
    if (good && e.bcast) cnt[b + 11]++;
    else if (good && e.mcast && !e.mac_ctrl) cnt[b + 12]++;
    else if (good && !e.mcast) cnt[b + 13]++;
  endtask : mdl_rx
  task mdl_tx(input int p, input tx_event_t e);
    int b;
    b = p * 32;
    if (e.ok) cnt[b + 20 + e.high_prio] += e.len;
    if (e.late_collide) cnt[b + 22]++;
    if (e.pause) cnt[b + 23]++;
    if (e.ok && !e.pause) cnt[b + (e.bcast ? 24 : e.mcast ? 25 : 26)]++;
    if (e.deferred) cnt[b + 27]++;
    cnt[b + 28] += e.collisions;
    if (e.abort) cnt[b + 29]++;
    if (e.ok && e.collisions == 1) cnt[b + 30]++;
    if (e.ok && e.collisions > 1) cnt[b + 31]++;
  endtask : mdl_tx
  task rd(input int i);
    i_stats_host_model.rd_counter(i[8:0], d);
    x = 32'h0;
    if (i < 96) begin
      x = {2'b01, cnt[i][29:0]};
      cnt[i] = 0;
    end else if (i >= 256 && i < 262) x = {16'h0, drp[i - 256][15:0]};
    check(d, x);
  endtask : rd
  task read_all();
    for (int i = 0; i < 96; i++) rd(i);
    for (int i = 256; i < 262; i++) rd(i);
    rd(96);
    rd(262);
    $display("test readback done");
  endtask : read_all
  task run_rand(input int n);
    logic [31:0] r;
    rx_event_t re;
    tx_event_t te;
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      for (int p = 0; p < 3; p++) begin
        r = rnd();
        re = r[20:0];
        re.len = 11'(40 + r % 1560);
        rx_ev[p] <= re;
        if (re.valid) mdl_rx(p, re);
        r = rnd();
        te = r[24:0];
        te.len = 11'(64 + r % 1460);
        te.ok = !te.abort;
        te.pause &= te.ok;
        te.deferred &= te.ok;
        tx_ev[p] <= te;
        if (te.valid) mdl_tx(p, te);
        txd[p] <= r[30];
        rxd[p] <= r[31];
        drp[p] += r[30];
        drp[p + 3] += r[31];
      end
    end
    @(posedge clk);
    rx_ev <= '0;
    tx_ev <= '0;
    txd <= 3'h0;
    rxd <= 3'h0;
    $display("test random done");
  endtask : run_rand
  // ==========================================================================
  // Sequence
  initial begin
    rx_event_t e;
    rst = 1'b1;
    rx_ev = '0;
    tx_ev = '0;
    txd = 3'h0;
    rxd = 3'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    i_stats_host_model.access(1'b0, ADR_DATA, 32'h0, d);
    check(d, DATA_RST);
    i_stats_host_model.access(1'b0, ADR_CONFIG, 32'h0, d);
    check(d, 32'h0);
    i_stats_host_model.access(1'b0, 8'h10, 32'h0, d);
    check(d, 32'h0);
    // Event landing on the very edge that snapshots and clears the counter
    i_stats_host_model.access(1'b1, ADR_TABLE_SEL, {24'h0, SEL_PORT_CNT}, d);
    e = '0;
    e.valid = 1'b1;
    e.len = LEN_MIN;
    e.crc_ok = 1'b1;
    repeat (2) begin
      @(posedge clk);
      rx_ev[0] <= e;
      mdl_rx(0, e);
    end
    @(posedge clk);
    rx_ev[0] <= '0;
    x = {2'b01, cnt[14][29:0]};
    cnt[14] = 0;
    mdl_rx(0, e);
    fork
      i_stats_host_model.access(1'b1, ADR_TRIGGER, 32'h0e, d);
      begin
        repeat (2) @(posedge clk);
        rx_ev[0] <= e;
        @(posedge clk);
        rx_ev[0] <= '0;
      end
    join
    i_stats_host_model.access(1'b0, ADR_DATA, 32'h0, d);
    check(d, x);
    rd(14);
    $display("test coincide done");
    run_rand(200);
    read_all();
    cfg = 1'b1;
    i_stats_host_model.access(1'b1, ADR_CONFIG, 32'h1, d);
    run_rand(200);
    read_all();
    read_all();
    run_rand(50);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cnt = '{default: 0};
    drp = '{default: 0};
    cfg = 1'b0;
    read_all();
    stop_test();
  end
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end
endmodule : port_statistics_counters_tb
